// ===== rtl/smr_pkg.sv
// Constants shared by the serial message recognizer.
package smr_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TERM_LO = 8'h08;
    localparam logic [7:0] OFS_TERM_HI = 8'h0C;
    localparam logic [7:0] OFS_TERM_LN = 8'h10;
    localparam logic [7:0] OFS_GAP     = 8'h14;
    localparam logic [7:0] OFS_HOLD    = 8'h18;
    localparam logic [7:0] OFS_CMD     = 8'h1C;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
    localparam logic [7:0] OFS_IRQ_MK  = 8'h24;
    localparam logic [7:0] OFS_P_FP    = 8'h28;
    localparam logic [7:0] OFS_P_LEN   = 8'h2C;
    localparam logic [7:0] OFS_P_TXT   = 8'h30;
    localparam logic [7:0] OFS_T_FP    = 8'h40;
    localparam logic [7:0] OFS_T_LEN   = 8'h44;
    localparam logic [7:0] OFS_T_TXT   = 8'h48;
    localparam logic [7:0] OFS_P_HEX   = 8'h60;
    localparam logic [7:0] OFS_T_HEX   = 8'h80;
    // ------------------------------------------------------------
    // Field values and sizes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_CTRL   = 2'h1;
    localparam logic [1:0] MODE_INJ    = 2'h2;
    localparam int         MSG_BYTES   = 12;
    localparam int         TXT_WORDS   = 3;
    localparam int         HEX_WORDS   = 6;
    localparam int         TERM_BYTES  = 8;
    localparam logic [3:0] TERM_MAX    = 4'h8;
    localparam logic [15:0] GAP_MIN_MS = 16'h000A;
    localparam logic [15:0] GAP_RST_MS = 16'h0000;
    localparam logic [7:0] HOLD_RST_MS = 8'h32;
    localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MS_NS         = 1000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/smr_ms_tick.sv
// Millisecond tick generator.
`timescale 1ns/1ps
module smr_ms_tick #(
    parameter int CYC_PER_MS = smr_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Tick
    output logic      tick
);
    localparam int CW = $clog2(CYC_PER_MS + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            tick  <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
        end
    end
endmodule // smr_ms_tick

// ===== rtl/smr_crc_byte.sv
// One-byte step of the reflected CRC-32 used as message fingerprint.
`timescale 1ns/1ps
module smr_crc_byte (
    // Running value and new byte
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data,
    // Updated value
    output logic      [31:0] crc_out
);
    always_comb
    begin
        crc_out = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ smr_pkg::CRC_POLY) : (crc_out >> 1);
        end
    end
endmodule // smr_crc_byte

// ===== rtl/smr_recognizer.sv
// Serial message recognizer with APB registers.
`timescale 1ns/1ps
module smr_recognizer #(
    parameter int CYC_PER_MS = smr_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Received serial bytes from the UART receiver
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Port control
    output logic      [1:0]  port_operation_select,
    output logic             injection_state_ro,
    // Interrupt
    output logic             irq
);
    localparam int MB = smr_pkg::MSG_BYTES;

    typedef struct packed {
        logic [1:0]      mode;
        logic            inj;
        logic            inj_st;
        logic            cap;
        logic [63:0]     term;
        logic [3:0]      tlen;
        logic [15:0]     gap;
        logic [7:0]      hold;
        logic [1:0]      irq_st;
        logic [1:0]      irq_mk;
        logic [MB*8-1:0] buf_;
        logic [3:0]      blen;
        logic [31:0]     crc;
        logic [63:0]     hist;
        logic [15:0]     gapc;
        logic [MB*8-1:0] p_txt;
        logic [3:0]      p_len;
        logic [31:0]     p_fp;
        logic [MB*8-1:0] t_txt;
        logic [3:0]      t_len;
        logic [31:0]     t_fp;
        logic [7:0]      holdc;
        logic            t_live;
        logic [31:0]     rdata;
    } smr_state_t;

    smr_state_t q;
    smr_state_t n;
    logic       tick;
    logic [31:0] crc_nx;
    logic       wr;
    logic       clr;
    logic       done;
    logic       match;
    logic [63:0] hist_nx;
    logic [15:0] gap_v;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    smr_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    smr_crc_byte u_crc (
        .crc_in  (q.crc),
        .data    (rx_data),
        .crc_out (crc_nx)
    );

    function automatic logic [7:0] hex_chr(input logic [3:0] v);
        hex_chr = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
    endfunction

    // Two stored bytes rendered as four ASCII hex characters, first byte on top.
    function automatic logic [31:0] hex_word(input logic [MB*8-1:0] txt,
                                             input logic [3:0] len, input logic [2:0] k);
        logic [7:0] b0;
        logic [7:0] b1;
        b0 = txt[{k, 4'h0} +: 8];
        b1 = txt[{k, 4'h8} +: 8];
        hex_word = '0;
        if ({k, 1'b0} < len)
            hex_word[31:16] = {hex_chr(b0[7:4]), hex_chr(b0[3:0])};
        if ({k, 1'b1} < len)
            hex_word[15:0] = {hex_chr(b1[7:4]), hex_chr(b1[3:0])};
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= smr_pkg::OFS_T_LEN + 8'h0C) ||
                  (a >= smr_pkg::OFS_P_HEX && a < smr_pkg::OFS_P_HEX + 8'h18) ||
                  (a >= smr_pkg::OFS_T_HEX && a < smr_pkg::OFS_T_HEX + 8'h18);
        // Only three text words exist, so the slot just above them stays unmapped.
        addr_ok = addr_ok && (a[1:0] == 2'h0) && (a != smr_pkg::OFS_P_TXT + 8'h0C);
    endfunction

    function automatic logic [31:0] rd_mux(input smr_state_t s, input logic [7:0] a);
        logic [7:0] r;
        rd_mux = '0;
        r = '0;
        if (a >= smr_pkg::OFS_T_HEX)
        begin
            r = a - smr_pkg::OFS_T_HEX;
            rd_mux = hex_word(s.t_txt, s.t_len, r[4:2]);
        end
        else if (a >= smr_pkg::OFS_P_HEX)
        begin
            r = a - smr_pkg::OFS_P_HEX;
            rd_mux = hex_word(s.p_txt, s.p_len, r[4:2]);
        end
        else if (a >= smr_pkg::OFS_T_TXT)
        begin
            r = a - smr_pkg::OFS_T_TXT;
            rd_mux = s.t_txt[{r[3:2], 5'h00} +: 32];
        end
        else if (a >= smr_pkg::OFS_P_TXT && a < smr_pkg::OFS_T_FP)
        begin
            r = a - smr_pkg::OFS_P_TXT;
            rd_mux = s.p_txt[{r[3:2], 5'h00} +: 32];
        end
        else
        begin
            unique case (a)
                smr_pkg::OFS_CTRL:    rd_mux = {28'h0, s.cap, s.inj, s.mode};
                smr_pkg::OFS_STATUS:  rd_mux = {23'h0, s.t_live, s.blen, 3'h0, s.inj_st};
                smr_pkg::OFS_TERM_LO: rd_mux = s.term[31:0];
                smr_pkg::OFS_TERM_HI: rd_mux = s.term[63:32];
                smr_pkg::OFS_TERM_LN: rd_mux = {28'h0, s.tlen};
                smr_pkg::OFS_GAP:     rd_mux = {16'h0, s.gap};
                smr_pkg::OFS_HOLD:    rd_mux = {24'h0, s.hold};
                smr_pkg::OFS_IRQ_ST:  rd_mux = {30'h0, s.irq_st};
                smr_pkg::OFS_IRQ_MK:  rd_mux = {30'h0, s.irq_mk};
                smr_pkg::OFS_P_FP:    rd_mux = s.p_fp;
                smr_pkg::OFS_P_LEN:   rd_mux = {28'h0, s.p_len};
                smr_pkg::OFS_T_FP:    rd_mux = s.t_fp;
                smr_pkg::OFS_T_LEN:   rd_mux = {28'h0, s.t_len};
                default:              rd_mux = '0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        n = q;
        wr = psel && penable && pwrite && addr_ok(paddr);
        clr = 1'b0;
        done = 1'b0;
        gap_v = pwdata[15:0];
        hist_nx = {q.hist[55:0], rx_data};
        match = (q.tlen != 4'h0);
        for (int i = 0; i < smr_pkg::TERM_BYTES; i++)
        begin
            if (4'(i) < q.tlen && hist_nx[i*8 +: 8] != q.term[i*8 +: 8])
                match = 1'b0;
        end
        if (psel && !penable && !pwrite)
            n.rdata = addr_ok(paddr) ? rd_mux(q, paddr) : '0;
        if (wr)
        begin
            unique case (paddr)
                smr_pkg::OFS_CTRL:
                begin
                    if (pwdata[1:0] <= smr_pkg::MODE_INJ)
                        n.mode = pwdata[1:0];
                    n.inj = pwdata[2];
                    n.cap = pwdata[3];
                end
                smr_pkg::OFS_TERM_LO: n.term[31:0] = pwdata;
                smr_pkg::OFS_TERM_HI: n.term[63:32] = pwdata;
                smr_pkg::OFS_TERM_LN:
                    n.tlen = (pwdata > 32'(smr_pkg::TERM_MAX)) ? smr_pkg::TERM_MAX
                                                              : pwdata[3:0];
                smr_pkg::OFS_GAP:
                    n.gap = (gap_v != 16'h0 && gap_v < smr_pkg::GAP_MIN_MS)
                            ? smr_pkg::GAP_MIN_MS : gap_v;
                smr_pkg::OFS_HOLD:   n.hold = pwdata[7:0];
                smr_pkg::OFS_CMD:    clr = pwdata[0];
                smr_pkg::OFS_IRQ_ST: n.irq_st = q.irq_st & ~pwdata[1:0];
                smr_pkg::OFS_IRQ_MK: n.irq_mk = pwdata[1:0];
                default:             n.rdata = n.rdata;
            endcase
        end
        n.inj_st = n.inj && (n.mode == smr_pkg::MODE_INJ);
        // Temporary copy lifetime.
        if (q.t_live && q.holdc >= q.hold)
        begin
            n.t_txt = '0;
            n.t_len = '0;
            n.t_fp = '0;
            n.t_live = 1'b0;
        end
        else if (q.t_live && tick)
            n.holdc = q.holdc + 8'h01;
        // Message assembly.
        if (!q.cap)
        begin
            n.blen = '0;
            n.buf_ = '0;
            n.crc = smr_pkg::CRC_INIT;
            n.gapc = '0;
            n.hist = '0;
        end
        else if (rx_valid)
        begin
            if (q.blen < 4'(MB))
            begin
                n.buf_[{q.blen, 3'h0} +: 8] = rx_data;
                n.blen = q.blen + 4'h1;
                n.crc = crc_nx;
            end
            n.hist = hist_nx;
            n.gapc = '0;
            done = match;
        end
        else if (q.blen != 4'h0 && q.gap != 16'h0)
        begin
            if (q.gapc >= q.gap)
                done = 1'b1;
            else if (tick)
                n.gapc = q.gapc + 16'h0001;
        end
        if (done)
        begin
            if (n.buf_ != q.p_txt || n.blen != q.p_len)
                n.irq_st[0] = 1'b1;
            n.p_txt = n.buf_;
            n.p_len = n.blen;
            n.p_fp = ~n.crc;
            n.t_txt = n.buf_;
            n.t_len = n.blen;
            n.t_fp = ~n.crc;
            n.t_live = 1'b1;
            n.holdc = '0;
            n.irq_st[1] = 1'b1;
            n.buf_ = '0;
            n.blen = '0;
            n.crc = smr_pkg::CRC_INIT;
            n.gapc = '0;
            n.hist = '0;
        end
        if (clr)
        begin
            n.p_txt = '0;
            n.p_len = '0;
            n.p_fp = '0;
            n.t_txt = '0;
            n.t_len = '0;
            n.t_fp = '0;
            n.t_live = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.mode <= smr_pkg::MODE_OFF;
            q.gap <= smr_pkg::GAP_RST_MS;
            q.hold <= smr_pkg::HOLD_RST_MS;
            q.crc <= smr_pkg::CRC_INIT;
        end
        else
        begin
            q <= n;
        end
    end

    // Single-cycle access keeps the bus simple; read data is captured in setup.
    assign pready                = 1'b1;
    assign pslverr               = psel && penable && !addr_ok(paddr);
    assign prdata                = q.rdata;
    assign port_operation_select = q.mode;
    assign injection_state_ro    = q.inj_st;
    assign irq                   = |(q.irq_st & q.irq_mk);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_clear_write;
        psel && penable && pwrite && paddr == smr_pkg::OFS_CMD && pwdata[0];
    endsequence

    sequence s_erased;
        q.p_len == 4'h0 && q.t_len == 4'h0 && q.p_fp == 32'h0 && !q.t_live;
    endsequence

    clear_erases_a: assert property (s_clear_write |=> s_erased)
        else $error("Clear left a stored message.");
    mode_legal_a: assert property (port_operation_select != 2'h3)
        else $error("Illegal port mode stored.");
    inj_status_a: assert property (injection_state_ro ==
        (q.inj && port_operation_select == smr_pkg::MODE_INJ))
        else $error("Injection status disagrees with enable and mode.");
    capture_off_a: assert property (!q.cap |=> q.blen == 4'h0)
        else $error("Bytes captured while capture disabled.");
    gap_floor_a: assert property (q.gap == 16'h0 || q.gap >= smr_pkg::GAP_MIN_MS)
        else $error("Gap limit below minimum.");
    term_close_a: assert property (q.cap && rx_valid && match && !clr
        |=> q.t_live && q.blen == 4'h0 && q.holdc == 8'h0)
        else $error("Terminator match did not close the message.");
    gap_close_a: assert property (q.cap && !rx_valid && q.blen != 4'h0 && q.gap != 16'h0
        && q.gapc >= q.gap |=> q.blen == 4'h0 && q.irq_st[1])
        else $error("Idle gap did not close the message.");
    hold_expire_a: assert property (q.t_live && q.holdc >= q.hold && !done
        |=> !q.t_live && q.t_len == 4'h0)
        else $error("Temporary copy outlived its hold time.");
    len_limit_a: assert property (q.blen <= 4'(MB) && q.p_len <= 4'(MB))
        else $error("Stored text exceeds twelve bytes.");
    same_copy_a: assert property (done && !clr |=> q.p_fp == q.t_fp && q.p_len == q.t_len)
        else $error("Copies not updated together.");
    irq_level_a: assert property (irq == |(q.irq_st & q.irq_mk))
        else $error("Interrupt output wrong.");
endmodule // smr_recognizer

// ===== dv/smr_serial_dev.sv
// Model of the serial device that feeds bytes into the recognizer.
`timescale 1ns/1ps
module smr_serial_dev (
    // Clock
    input  wire logic       pclk,
    // Received byte stream
    output logic            rx_valid,
    output logic      [7:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'hA5;
    end
    // ------------------------------------------------------------
    // Byte sender
    // ------------------------------------------------------------
    // Data flips on every gap cycle after each byte and once more after the last byte, so logic that samples the byte
    // without its strobe cannot pass on a settled leftover value.
    task automatic send_msg(input string s, input int gap);
        for (int i = 0; i < s.len(); i++)
        begin
            rx_valid <= 1'b1;
            rx_data  <= s[i];
            @(posedge pclk);
            for (int g = 0; g < gap; g++)
            begin
                rx_valid <= 1'b0;
                rx_data  <= ~rx_data;
                @(posedge pclk);
            end
        end
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
    endtask
endmodule // smr_serial_dev

// ===== dv/smr_recognizer_tb.sv
// Self-checking testbench of the serial message recognizer.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module smr_recognizer_tb;
    // A short millisecond keeps every timed scenario within a few hundred cycles.
    localparam int CPM = 10;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        rx_valid, injection_state_ro, irq;
    logic [7:0]  rx_data;
    logic [1:0]  port_operation_select;
    int          n_mismatch, checks_done;

    smr_recognizer #(.CYC_PER_MS(CPM)) u_smr_recognizer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .port_operation_select(port_operation_select),
        .injection_state_ro(injection_state_ro), .irq(irq));
    smr_serial_dev u_smr_serial_dev (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Bus and reference helpers
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int   n;
        logic to;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        to = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (to)
        begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
    endtask
    function automatic logic [31:0] fp(input string s);
        logic [31:0] c;
        c = smr_pkg::CRC_INIT;
        for (int i = 0; i < s.len(); i++)
        begin
            c = c ^ {24'h0, s[i]};
            for (int b = 0; b < 8; b++)
            begin
                c = c[0] ? ((c >> 1) ^ smr_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return ~c;
    endfunction
    function automatic logic [7:0] hc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction
    function automatic logic [31:0] hexw(input string s, input int k);
        logic [7:0] a;
        logic [7:0] b;
        a = s[2*k];
        b = s[2*k+1];
        return {hc(a[7:4]), hc(a[3:0]), hc(b[7:4]), hc(b[3:0])};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(smr_pkg::OFS_CTRL, 32'h0);
        chk(smr_pkg::OFS_HOLD, 32'h32);
        chk(smr_pkg::OFS_GAP, 32'h0);
        `CHK(port_operation_select, 2'h0)
        $display("test reset done");
    endtask
    task automatic t_mode;
        logic [31:0] r;
        logic        e;
        for (int m = 0; m < 3; m++)
        begin
            wr(smr_pkg::OFS_CTRL, 32'(m) | 32'h4);
            `CHK(port_operation_select, 2'(m))
            `CHK(injection_state_ro, 1'(m == 2))
        end
        wr(smr_pkg::OFS_CTRL, 32'h7);
        `CHK(port_operation_select, 2'h2)
        wr(smr_pkg::OFS_STATUS, 32'h0);
        chk(smr_pkg::OFS_STATUS, 32'h1);
        wr(smr_pkg::OFS_CTRL, 32'h2);
        `CHK(injection_state_ro, 1'b0)
        xfer(1'b0, 8'hFC, 32'h0, r, e);
        `CHK(e, 1'b1)
        `CHK(r, 32'h0)
        $display("test mode done");
    endtask
    task automatic t_term;
        wr(smr_pkg::OFS_TERM_LO, 32'h3A);
        wr(smr_pkg::OFS_TERM_LN, 32'h1);
        wr(smr_pkg::OFS_HOLD, 32'hFF);
        wr(smr_pkg::OFS_IRQ_MK, 32'h1);
        wr(smr_pkg::OFS_CTRL, 32'h8);
        u_smr_serial_dev.send_msg("Lo:", 0);
        chk(smr_pkg::OFS_P_LEN, 32'h3);
        chk(smr_pkg::OFS_T_LEN, 32'h3);
        chk(smr_pkg::OFS_P_FP, fp("Lo:"));
        chk(smr_pkg::OFS_T_FP, fp("Lo:"));
        chk(smr_pkg::OFS_P_HEX, hexw("Lo:", 0));
        chk(smr_pkg::OFS_P_HEX + 8'h04, 32'h33410000);
        chk(smr_pkg::OFS_T_HEX, hexw("Lo:", 0));
        chk(smr_pkg::OFS_T_TXT, 32'h003A6F4C);
        `CHK(irq, 1'b1)
        chk(smr_pkg::OFS_IRQ_ST, 32'h3);
        wr(smr_pkg::OFS_IRQ_ST, 32'h3);
        `CHK(irq, 1'b0)
        u_smr_serial_dev.send_msg("Lo:", 2);
        chk(smr_pkg::OFS_IRQ_ST, 32'h2);
        `CHK(irq, 1'b0)
        wr(smr_pkg::OFS_IRQ_ST, 32'h3);
        wr(smr_pkg::OFS_CTRL, 32'h0);
        u_smr_serial_dev.send_msg("XY:", 0);
        chk(smr_pkg::OFS_P_FP, fp("Lo:"));
        chk(smr_pkg::OFS_IRQ_ST, 32'h0);
        $display("test terminator done");
    endtask
    task automatic t_long;
        wr(smr_pkg::OFS_TERM_LO, 32'h34353637);
        wr(smr_pkg::OFS_TERM_HI, 32'h30313233);
        wr(smr_pkg::OFS_TERM_LN, 32'h8);
        wr(smr_pkg::OFS_CTRL, 32'h8);
        u_smr_serial_dev.send_msg("ABCDEF01234567", 0);
        chk(smr_pkg::OFS_P_LEN, 32'hC);
        chk(smr_pkg::OFS_T_LEN, 32'hC);
        chk(smr_pkg::OFS_P_TXT, 32'h44434241);
        chk(smr_pkg::OFS_P_TXT + 8'h08, 32'h35343332);
        chk(smr_pkg::OFS_P_FP, fp("ABCDEF012345"));
        chk(smr_pkg::OFS_P_HEX + 8'h14, hexw("ABCDEF012345", 5));
        $display("test long done");
    endtask
    task automatic t_gap;
        wr(smr_pkg::OFS_TERM_LN, 32'h0);
        wr(smr_pkg::OFS_GAP, 32'h5);
        chk(smr_pkg::OFS_GAP, 32'hA);
        u_smr_serial_dev.send_msg("AB", 0);
        repeat (80) @(posedge pclk);
        chk(smr_pkg::OFS_P_LEN, 32'hC);
        repeat (40) @(posedge pclk);
        chk(smr_pkg::OFS_P_LEN, 32'h2);
        chk(smr_pkg::OFS_P_FP, fp("AB"));
        $display("test gap done");
    endtask
    task automatic t_hold;
        wr(smr_pkg::OFS_GAP, 32'h0);
        wr(smr_pkg::OFS_TERM_LO, 32'h3A);
        wr(smr_pkg::OFS_TERM_LN, 32'h1);
        wr(smr_pkg::OFS_HOLD, 32'h3);
        u_smr_serial_dev.send_msg("Lo:", 0);
        chk(smr_pkg::OFS_T_LEN, 32'h3);
        repeat (45) @(posedge pclk);
        chk(smr_pkg::OFS_T_LEN, 32'h0);
        chk(smr_pkg::OFS_T_FP, 32'h0);
        chk(smr_pkg::OFS_P_LEN, 32'h3);
        $display("test hold done");
    endtask
    task automatic t_clear;
        wr(smr_pkg::OFS_HOLD, 32'hFF);
        u_smr_serial_dev.send_msg("Lo:", 0);
        wr(smr_pkg::OFS_CMD, 32'h1);
        chk(smr_pkg::OFS_P_LEN, 32'h0);
        chk(smr_pkg::OFS_P_FP, 32'h0);
        chk(smr_pkg::OFS_P_HEX, 32'h0);
        chk(smr_pkg::OFS_T_LEN, 32'h0);
        chk(smr_pkg::OFS_T_TXT, 32'h0);
        $display("test clear done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial
    begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        n_mismatch  = 0;
        checks_done = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_mode();
        t_term();
        t_long();
        t_gap();
        t_hold();
        t_clear();
        results();
    end
endmodule // smr_recognizer_tb
